// ==== design/reset_sequencer.sv ====
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module reset_sequencer #(
	parameter int WDG_OUT_MIN_NS = 1000
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        rst_pin_in,
	output logic             rst_pin_out,
	output logic             rst_pin_oe,
	input  wire logic        supply_low,
	input  wire logic        wdg_underflow,
	input  wire logic        illegal_op,
	output logic             cpu_rst,
	output logic             vec_fetch,
	output logic [15:0]      vec_addr,
	output logic             irq,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp
);
	localparam int WDG_CYC = (WDG_OUT_MIN_NS + rst_seq_pkg::CLK_PERIOD_NS - 1)
		/ rst_seq_pkg::CLK_PERIOD_NS;
	localparam logic [15:0] WDG_LOAD = (WDG_CYC < 1) ? 16'h0001 : 16'(WDG_CYC);

	rst_seq_pkg::phase_t   state_q, state_d;
	rst_seq_pkg::clk_src_t clk_src_q;
	rst_seq_pkg::cause_t   cause_q;
	rst_seq_pkg::ahb_ap_t  ap_q;
	logic                  sup_en_q;
	logic [15:0]           wdg_cnt_q;
	logic [rst_seq_pkg::CNT_W-1:0] dly_cnt;
	logic [rst_seq_pkg::CNT_W-1:0] dly_len;
	logic [rst_seq_pkg::EV_W-1:0]  ev_stat_q, ev_mask_q, ev_set;
	logic ext_req, sup_req, wdg_hold, any_req, dly_done;
	logic ap_take, wr_go, rd_go;

	// own drive masked, else the pin we pull low would re-arm us
	assign ext_req  = !rst_pin_in && !rst_pin_oe;
	assign sup_req  = supply_low && sup_en_q;
	assign wdg_hold = wdg_underflow || (wdg_cnt_q != 16'h0000);
	assign any_req  = ext_req || sup_req || wdg_hold || illegal_op;
	assign dly_len  = rst_seq_pkg::dly_len(clk_src_q);
	assign dly_done = (dly_cnt == dly_len - rst_seq_pkg::CNT_W'(1));

	rst_delay_counter u_dly (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.clear   (state_q != rst_seq_pkg::PH_DELAY),
		.run     (state_q == rst_seq_pkg::PH_DELAY),
		.count_q (dly_cnt)
	);

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			wdg_cnt_q <= 16'h0000;
		else if (wdg_underflow)
			wdg_cnt_q <= WDG_LOAD;
		else if (wdg_cnt_q != 16'h0000)
			wdg_cnt_q <= wdg_cnt_q - 16'h0001;
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			rst_seq_pkg::PH_RUN: begin
				if (any_req)
					state_d = rst_seq_pkg::PH_ACTIVE;
			end
			rst_seq_pkg::PH_ACTIVE: begin
				if (!any_req)
					state_d = rst_seq_pkg::PH_DELAY;
			end
			rst_seq_pkg::PH_DELAY: begin
				if (any_req)
					state_d = rst_seq_pkg::PH_ACTIVE;
				else if (dly_done)
					state_d = rst_seq_pkg::PH_FETCH;
			end
			rst_seq_pkg::PH_FETCH: begin
				if (any_req)
					state_d = rst_seq_pkg::PH_ACTIVE;
				else if (vec_addr == rst_seq_pkg::VEC_HI)
					state_d = rst_seq_pkg::PH_RUN;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			state_q <= rst_seq_pkg::PH_ACTIVE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rst_pin_oe  <= 1'b1;
			rst_pin_out <= 1'b0;
			cpu_rst     <= 1'b1;
		end else begin
			rst_pin_oe  <= (state_d == rst_seq_pkg::PH_DELAY) ||
				((state_d == rst_seq_pkg::PH_ACTIVE) && (sup_req || wdg_hold));
			rst_pin_out <= 1'b0;
			cpu_rst     <= (state_d == rst_seq_pkg::PH_ACTIVE) ||
				(state_d == rst_seq_pkg::PH_DELAY);
		end
	end

	// fetch walks low byte then high byte of the vector
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			vec_fetch <= 1'b0;
			vec_addr  <= rst_seq_pkg::VEC_LO;
		end else begin
			vec_fetch <= (state_d == rst_seq_pkg::PH_FETCH);
			if (state_d == rst_seq_pkg::PH_FETCH && state_q == rst_seq_pkg::PH_FETCH)
				vec_addr <= rst_seq_pkg::VEC_HI;
			else
				vec_addr <= rst_seq_pkg::VEC_LO;
		end
	end

	assign ap_take = hsel && hready && (htrans == rst_seq_pkg::HTRANS_NONSEQ);
	assign wr_go   = ap_q.valid && ap_q.write;
	assign rd_go   = ap_take && !hwrite;

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			ap_q <= '0;
		else if (hready)
			ap_q <= '{valid: ap_take, write: hwrite, addr: {haddr[7:2], 2'b00}};
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			clk_src_q <= rst_seq_pkg::OPT_SRC_RST;
			sup_en_q  <= 1'b1;
		end else if (wr_go && ap_q.addr == rst_seq_pkg::OFF_OPTION) begin
			clk_src_q <= rst_seq_pkg::clk_src_t'(hwdata[2:0]);
			sup_en_q  <= hwdata[rst_seq_pkg::OPT_SUP_EN];
		end
	end

	// sets beat clears; a supply request always wipes the watchdog flag
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cause_q <= '0;
		end else begin
			if (sup_req)
				cause_q.sup <= 1'b1;
			else if (rd_go && {haddr[7:2], 2'b00} == rst_seq_pkg::OFF_CAUSE)
				cause_q.sup <= 1'b0;
			if (sup_req)
				cause_q.wdg <= 1'b0;
			else if (wdg_underflow)
				cause_q.wdg <= 1'b1;
			else if (wr_go && ap_q.addr == rst_seq_pkg::OFF_CAUSE &&
				!hwdata[rst_seq_pkg::CAUSE_WDG])
				cause_q.wdg <= 1'b0;
		end
	end

	always_comb begin
		ev_set = '0;
		ev_set[rst_seq_pkg::EV_PIN]  = ext_req;
		ev_set[rst_seq_pkg::EV_SUP]  = sup_req;
		ev_set[rst_seq_pkg::EV_WDG]  = wdg_underflow;
		ev_set[rst_seq_pkg::EV_ILL]  = illegal_op;
		ev_set[rst_seq_pkg::EV_DONE] = (state_q == rst_seq_pkg::PH_FETCH) &&
			(state_d == rst_seq_pkg::PH_RUN);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ev_stat_q <= '0;
			ev_mask_q <= rst_seq_pkg::IRQ_MASK_RST;
		end else begin
			if (wr_go && ap_q.addr == rst_seq_pkg::OFF_IRQ_STAT)
				ev_stat_q <= (ev_stat_q & ~hwdata[rst_seq_pkg::EV_W-1:0]) | ev_set;
			else
				ev_stat_q <= ev_stat_q | ev_set;
			if (wr_go && ap_q.addr == rst_seq_pkg::OFF_IRQ_MASK)
				ev_mask_q <= hwdata[rst_seq_pkg::EV_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |(ev_stat_q & ev_mask_q);
	end

	// zero wait states: read data registered during the address phase
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (rd_go) begin
			unique case ({haddr[7:2], 2'b00})
				rst_seq_pkg::OFF_CAUSE:    hrdata <= {30'h0, cause_q};
				rst_seq_pkg::OFF_OPTION:   hrdata <= {28'h0, sup_en_q, clk_src_q};
				rst_seq_pkg::OFF_PHASE:    hrdata <= {30'h0, state_q};
				rst_seq_pkg::OFF_IRQ_STAT: hrdata <= {27'h0, ev_stat_q};
				rst_seq_pkg::OFF_IRQ_MASK: hrdata <= {27'h0, ev_mask_q};
				default:                   hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// helper: length of the current uninterrupted delay run
	logic [rst_seq_pkg::CNT_W-1:0] dly_run_q;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || state_q != rst_seq_pkg::PH_DELAY)
			dly_run_q <= '0;
		else
			dly_run_q <= dly_run_q + rst_seq_pkg::CNT_W'(1);
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	property p_pin_low_delay;
		(state_q == rst_seq_pkg::PH_DELAY) |-> rst_pin_oe && !rst_pin_out;
	endproperty
	a_pin_low_delay: assert property (p_pin_low_delay)
		else $error("pin not driven low in delay");

	property p_fetch_two;
		$rose(vec_fetch) |-> vec_fetch ##1 (vec_fetch || $past(any_req))
			##1 (!vec_fetch || $past(any_req, 2));
	endproperty
	a_fetch_two: assert property (p_fetch_two)
		else $error("fetch phase not two cycles");

	property p_vec_addr;
		$rose(vec_fetch) |-> vec_addr == rst_seq_pkg::VEC_LO
			##1 (!vec_fetch || vec_addr == rst_seq_pkg::VEC_HI);
	endproperty
	a_vec_addr: assert property (p_vec_addr)
		else $error("wrong vector address");

	property p_dly_long;
		(state_q == rst_seq_pkg::PH_DELAY && state_d == rst_seq_pkg::PH_FETCH &&
			clk_src_q != rst_seq_pkg::SRC_RC_SLOW &&
			clk_src_q != rst_seq_pkg::SRC_XTAL_KHZ)
			|-> dly_run_q == rst_seq_pkg::DLY_LONG - rst_seq_pkg::CNT_W'(1);
	endproperty
	a_dly_long: assert property (p_dly_long)
		else $error("long delay length wrong");

	property p_dly_short;
		(state_q == rst_seq_pkg::PH_DELAY && state_d == rst_seq_pkg::PH_FETCH &&
			(clk_src_q == rst_seq_pkg::SRC_RC_SLOW ||
			clk_src_q == rst_seq_pkg::SRC_XTAL_KHZ))
			|-> dly_run_q == rst_seq_pkg::DLY_SHORT - rst_seq_pkg::CNT_W'(1);
	endproperty
	a_dly_short: assert property (p_dly_short)
		else $error("short delay length wrong");

	property p_sup_hold;
		(supply_low && sup_en_q) |=> cpu_rst && rst_pin_oe && cause_q.sup;
	endproperty
	a_sup_hold: assert property (p_sup_hold)
		else $error("supply low without reset");

	property p_sup_off;
		(!sup_en_q && !cause_q.sup) |=> !cause_q.sup;
	endproperty
	a_sup_off: assert property (p_sup_off)
		else $error("supply flag set while monitor off");

	property p_wdg_pulse;
		$rose(wdg_underflow) |=> rst_pin_oe [*8];
	endproperty
	a_wdg_pulse: assert property (p_wdg_pulse)
		else $error("watchdog pin pulse too short");

	property p_sup_wins;
		(supply_low && sup_en_q) |=> !cause_q.wdg;
	endproperty
	a_sup_wins: assert property (p_sup_wins)
		else $error("watchdog flag survived supply reset");

	property p_sup_sticky;
		(cause_q.sup && !rd_go) |=> cause_q.sup;
	endproperty
	a_sup_sticky: assert property (p_sup_sticky)
		else $error("supply flag lost without read");

	property p_restart;
		(state_q == rst_seq_pkg::PH_DELAY && any_req) |=>
			state_q == rst_seq_pkg::PH_ACTIVE ##1 dly_cnt == '0;
	endproperty
	a_restart: assert property (p_restart)
		else $error("delay not restarted");

	property p_illegal;
		illegal_op |=> cpu_rst;
	endproperty
	a_illegal: assert property (p_illegal)
		else $error("illegal opcode did not reset");

	c_full_seq: cover property (state_q == rst_seq_pkg::PH_FETCH ##1
		state_q == rst_seq_pkg::PH_FETCH ##1 state_q == rst_seq_pkg::PH_RUN);
	c_wdg: cover property (wdg_underflow ##[1:600] state_q == rst_seq_pkg::PH_DELAY);
	c_sup: cover property (sup_req ##1 !sup_req);
	c_restart: cover property (state_q == rst_seq_pkg::PH_DELAY && any_req);
endmodule // reset_sequencer

// ==== design/rst_seq_pkg.sv ====
// Operation
// - pin, supply, watchdog, illegal opcode start reset
// - supply and watchdog drive pin; every source low through delay
// - start address from top two bytes
// - active phase, counted delay, two-cycle fetch
// - delay length picked from clock source option
// - fast clock sources give 4096-cycle delay
// - 32 kHz sources give 256-cycle delay
// - pin low detected without any clock enable
// - pin is input and low-only open drain
// - supply low holds reset and pin low
// - option bit disables supply monitor requests
// - watchdog drives pin low minimum width
// - supply reset wins, clears watchdog flag
// - two flags encode last reset cause
// - supply flag sticky, cleared by reading
package rst_seq_pkg;
	localparam logic [7:0] OFF_CAUSE    = 8'h00;
	localparam logic [7:0] OFF_OPTION   = 8'h04;
	localparam logic [7:0] OFF_PHASE    = 8'h08;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
	localparam int CAUSE_SUP = 0;
	localparam int CAUSE_WDG = 1;
	localparam int OPT_SUP_EN = 3;
	localparam int EV_PIN  = 0;
	localparam int EV_SUP  = 1;
	localparam int EV_WDG  = 2;
	localparam int EV_ILL  = 3;
	localparam int EV_DONE = 4;
	localparam int EV_W    = 5;
	localparam logic [15:0] VEC_LO = 16'hfffe;
	localparam logic [15:0] VEC_HI = 16'hffff;
	localparam int CNT_W = 13;
	localparam logic [CNT_W-1:0] DLY_LONG  = 13'h1000;
	localparam logic [CNT_W-1:0] DLY_SHORT = 13'h0100;
	localparam int CLK_PERIOD_NS = 4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;

	typedef enum logic [1:0] {
		PH_RUN    = 2'b00,
		PH_ACTIVE = 2'b01,
		PH_DELAY  = 2'b10,
		PH_FETCH  = 2'b11
	} phase_t;

	typedef enum logic [2:0] {
		SRC_RC_FAST  = 3'b000,
		SRC_RC_SLOW  = 3'b001,
		SRC_EXT_CLK  = 3'b010,
		SRC_XTAL     = 3'b011,
		SRC_XTAL_MHZ = 3'b100,
		SRC_XTAL_KHZ = 3'b101
	} clk_src_t;

	localparam clk_src_t OPT_SRC_RST = SRC_RC_FAST;

	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} ahb_ap_t;

	typedef struct packed {
		logic wdg;
		logic sup;
	} cause_t;

	// slow sources start fast, so a short settle suffices
	function automatic logic [CNT_W-1:0] dly_len(input clk_src_t src);
		if (src == SRC_RC_SLOW || src == SRC_XTAL_KHZ)
			return DLY_SHORT;
		return DLY_LONG;
	endfunction
endpackage

// ==== design/rst_delay_counter.sv ====
`timescale 1ns/1ps
module rst_delay_counter (
	input  wire logic                           ref_clk,
	input  wire logic                           sys_rst,
	input  wire logic                           clear,
	input  wire logic                           run,
	output logic [rst_seq_pkg::CNT_W-1:0]       count_q
);
	always_ff @(posedge ref_clk) begin
		if (sys_rst || clear)
			count_q <= '0;
		else if (run)
			count_q <= count_q + rst_seq_pkg::CNT_W'(1);
	end
endmodule // rst_delay_counter

// ==== sim/ext_reset_board.sv ====
`timescale 1ns/1ps
// board side of the reset pin: weak pull-up plus an outside pull-down
module ext_reset_board (
	input  wire logic ext_low,
	input  wire logic rst_pin_out,
	input  wire logic rst_pin_oe,
	output logic      rst_pin_in
);
	// wired-and of all pull-downs; pull-up gives 1 when nobody pulls
	assign rst_pin_in = ~ext_low & ~(rst_pin_oe & ~rst_pin_out);
endmodule // ext_reset_board

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb;
	logic        ref_clk = 0;
	logic        sys_rst = 1;
	logic        ext_low = 0;
	logic        supply_low = 0;
	logic        wdg_underflow = 0;
	logic        illegal_op = 0;
	logic        hwrite = 0;
	logic [1:0]  htrans = 0;
	logic [31:0] haddr = 0;
	logic [31:0] hwdata = 0;
	logic        rst_pin_in, rst_pin_out, rst_pin_oe, cpu_rst, vec_fetch, irq;
	logic        hreadyout, hresp;
	logic [15:0] vec_addr;
	logic [31:0] hrdata, rd;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cnt;

	always #2 ref_clk = ~ref_clk;

	// long hold so the watchdog pulse outlasts the short settle delay
	reset_sequencer #(.WDG_OUT_MIN_NS(2000)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
		.supply_low(supply_low), .wdg_underflow(wdg_underflow), .illegal_op(illegal_op),
		.cpu_rst(cpu_rst), .vec_fetch(vec_fetch), .vec_addr(vec_addr), .irq(irq),
		.hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp));
	ext_reset_board board (.ext_low(ext_low), .rst_pin_out(rst_pin_out),
		.rst_pin_oe(rst_pin_oe), .rst_pin_in(rst_pin_in));

	task end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task tick;
		@(posedge ref_clk);
		#1;
	endtask
	// ready is looked at on the edge itself, before the slave updates it
	task wait_rdy;
		int i;
		for (i = 0; i < 50; i++) begin
			@(posedge ref_clk);
			if (hreadyout === 1'b1) break;
		end
		#1;
		if (i == 50) begin mismatches++; end_sim; end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		htrans <= rst_seq_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	// pulse well above any minimum width
	task pin_rst;
		ext_low <= 1;
		repeat (3) tick;
		`CHK(cpu_rst, 1'b1)
		ext_low <= 0;
	endtask
	// counts cycles with the pin pulled by us until the fetch starts
	task run_seq(output int n);
		int i;
		n = 0;
		for (i = 0; i < 20000; i++) begin
			tick;
			if (vec_fetch === 1'b1) break;
			if (rst_pin_oe === 1'b1) n++;
		end
		if (i == 20000) begin mismatches++; end_sim; end
		`CHK(vec_addr, rst_seq_pkg::VEC_LO)
		tick;
		`CHK(vec_addr, rst_seq_pkg::VEC_HI)
		tick;
		`CHK({vec_fetch, cpu_rst}, 2'b00)
	endtask

	initial begin
		repeat (12) tick;
		sys_rst <= 0;
		run_seq(cnt);
		bus(0, rst_seq_pkg::OFF_OPTION, 0);
		`CHK(rd, 32'h8)
		bus(0, rst_seq_pkg::OFF_IRQ_MASK, 0);
		`CHK(rd, 32'h0)
		bus(0, 8'h40, 0);
		`CHK(rd, 32'h0)
		bus(0, rst_seq_pkg::OFF_PHASE, 0);
		`CHK(rd, 32'h0)
		$display("test power_up done");
		for (int s = 0; s < 6; s++) begin
			bus(1, rst_seq_pkg::OFF_OPTION, 32'h8 | s);
			pin_rst;
			run_seq(cnt);
			`CHK(cnt, (s == 1 || s == 5) ? 256 : 4096)
		end
		$display("test clock_sources done");
		// short delay source stays selected until sys_rst is raised again
		pin_rst;
		repeat (100) tick;
		illegal_op <= 1;
		tick;
		illegal_op <= 0;
		run_seq(cnt);
		`CHK(cnt >= 256 && cnt <= 262, 1'b1)
		$display("test restart done");
		wdg_underflow <= 1;
		tick;
		wdg_underflow <= 0;
		run_seq(cnt);
		`CHK(cnt >= 756 && cnt <= 760, 1'b1)
		bus(0, rst_seq_pkg::OFF_CAUSE, 0);
		`CHK(rd, 32'h2)
		supply_low <= 1;
		repeat (20) tick;
		`CHK({rst_pin_oe, rst_pin_out, cpu_rst}, 3'b101)
		supply_low <= 0;
		run_seq(cnt);
		// a read clears the supply flag, so look only after the pin reset
		pin_rst;
		run_seq(cnt);
		bus(0, rst_seq_pkg::OFF_CAUSE, 0);
		`CHK(rd, 32'h1)
		bus(0, rst_seq_pkg::OFF_CAUSE, 0);
		`CHK(rd, 32'h0)
		wdg_underflow <= 1;
		tick;
		wdg_underflow <= 0;
		run_seq(cnt);
		bus(0, rst_seq_pkg::OFF_CAUSE, 0);
		`CHK(rd, 32'h2)
		bus(1, rst_seq_pkg::OFF_CAUSE, 32'h0);
		bus(0, rst_seq_pkg::OFF_CAUSE, 0);
		`CHK(rd, 32'h0)
		$display("test causes done");
		bus(1, rst_seq_pkg::OFF_OPTION, 32'h5);
		supply_low <= 1;
		repeat (20) tick;
		`CHK(cpu_rst, 1'b0)
		// monitor off: the board keeps the pin low for low supply or blank memory
		ext_low <= 1;
		repeat (40) tick;
		`CHK({cpu_rst, vec_fetch, rst_pin_oe}, 3'b100)
		supply_low <= 0;
		ext_low <= 0;
		run_seq(cnt);
		`CHK(cnt, 256)
		$display("test monitor_off done");
		bus(0, rst_seq_pkg::OFF_IRQ_STAT, 0);
		`CHK(rd, 32'h1f)
		`CHK(irq, 1'b0)
		bus(1, rst_seq_pkg::OFF_IRQ_MASK, 32'h10);
		repeat (2) tick;
		`CHK(irq, 1'b1)
		bus(1, rst_seq_pkg::OFF_IRQ_STAT, 32'h1f);
		repeat (2) tick;
		`CHK({irq, hresp}, 2'b00)
		$display("test irq done");
		sys_rst <= 1;
		repeat (2) tick;
		`CHK({cpu_rst, rst_pin_oe, vec_fetch, irq}, 4'b1100)
		sys_rst <= 0;
		run_seq(cnt);
		`CHK(cnt, 4096)
		$display("test mid_reset done");
		end_sim;
	end
endmodule // tb
